// ---- inc/apd_pkg.sv ----
// shared constants and types of the command engine
package apd_pkg;
  // register byte offsets
  localparam logic [5:0] OFS_SECCNT = 6'h00;
  localparam logic [5:0] OFS_SECNUM = 6'h04;
  localparam logic [5:0] OFS_CYLLO = 6'h08;
  localparam logic [5:0] OFS_CYLHI = 6'h0C;
  localparam logic [5:0] OFS_DRVHEAD = 6'h10;
  localparam logic [5:0] OFS_CMD = 6'h14;
  localparam logic [5:0] OFS_ERROR = 6'h18;
  localparam logic [5:0] OFS_DEVCTL = 6'h1C;
  localparam logic [5:0] OFS_CFG = 6'h20;
  localparam logic [5:0] OFS_IRQSTS = 6'h24;
  localparam logic [5:0] OFS_IRQMSK = 6'h28;
  // opcodes
  localparam logic [7:0] OPC_QUERY_A = 8'h98;
  localparam logic [7:0] OPC_QUERY_B = 8'hE5;
  localparam logic [7:0] OPC_ERASE = 8'hC0;
  localparam logic [7:0] OPC_DIAG = 8'h90;
  localparam logic [7:0] OPC_FLUSH = 8'hE7;
  // field positions
  localparam int DH_DRV = 4;
  localparam int DC_SRST = 2;
  localparam int DC_NIEN = 1;
  localparam int CFG_IDE = 0;
  localparam int CFG_SLAVE = 1;
  localparam int CFG_FLUSH = 2;
  localparam int CFG_PWR = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_REFUSED = 2;
  // values
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_FMT = 8'h02;
  localparam logic [7:0] DIAG_BUF = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] DIAG_SLAVE = 8'h80;
  localparam logic [7:0] SECCNT_STANDBY = 8'h00;
  localparam logic [7:0] SECCNT_IDLE = 8'hFF;
  localparam logic [1:0] PWR_IDLE = 2'b00;
  // reset values
  localparam logic [7:0] RST_TASK = 8'h00;
  localparam logic [7:0] RST_ERROR = 8'h01;
  localparam logic [7:0] RST_DEVCTL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h04;
  localparam logic [2:0] RST_IRQ = 3'b000;
  // timing
  localparam int CLK_NS = 4;
  localparam int BSY_MAX_NS = 400;
  localparam int BSY_MAX_CYC = BSY_MAX_NS / CLK_NS;
  localparam int ERASE_SEC_CYC = 4;
  localparam int DIAG_CYC = 32;
  localparam int FLUSH_CYC = 64;
  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_DIAG = 2'b01,
    OP_FLUSH = 2'b10
  } apd_op_type;
  typedef enum logic [2:0] {
    CK_QUERY = 3'b000,
    CK_ERASE = 3'b001,
    CK_DIAG = 3'b010,
    CK_FLUSH = 3'b011,
    CK_ABORT = 3'b100
  } apd_cmd_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FIN = 2'b10
  } apd_state_type;
endpackage

// ---- inc/apd_op_if.sv ----
// link between command control and the media operation engine
`timescale 1ns/1ps
interface apd_op_if;
  logic start;
  apd_pkg::apd_op_type op;
  logic [7:0] secCount;
  logic abort;
  logic done;
  logic fault;
  modport ctrl(output start, output op, output secCount, output abort, input done, input fault);
  modport engine(input start, input op, input secCount, input abort, output done, output fault);
endinterface

// ---- src/apd_op_engine.sv ----
// media operation engine: timed erase, self test and cache flush
`timescale 1ns/1ps
module apd_op_engine (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cacheDirty,
  input wire logic mediaFault,
  apd_op_if.engine ops
);
  logic [10:0] count_reg;
  logic running_reg;
  logic done_reg;
  logic fault_reg;
  apd_pkg::apd_op_type op_reg;
  logic [8:0] nSec;
  logic [10:0] workLen;

  // zero sectors means 256
  assign nSec = (ops.secCount == 8'h00) ? 9'h100 : {1'b0, ops.secCount};
  // a clean cache still costs one cycle so completion is always a separate edge
  assign workLen = (ops.op == apd_pkg::OP_ERASE) ? 11'(nSec * apd_pkg::ERASE_SEC_CYC) :
                   (ops.op == apd_pkg::OP_DIAG) ? 11'(apd_pkg::DIAG_CYC) :
                   (cacheDirty ? 11'(apd_pkg::FLUSH_CYC) : 11'h001);
  assign ops.done = done_reg;
  assign ops.fault = fault_reg;

  always_ff @(posedge core_clk) begin
    if (srst || ops.abort) begin
      count_reg <= 11'h000;
      running_reg <= 1'b0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      op_reg <= apd_pkg::OP_ERASE;
    end else if (ops.start) begin
      count_reg <= workLen;
      running_reg <= 1'b1;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      op_reg <= ops.op;
    end else if (running_reg && count_reg == 11'h001) begin
      running_reg <= 1'b0;
      done_reg <= 1'b1;
      fault_reg <= (op_reg == apd_pkg::OP_ERASE) && mediaFault;
      count_reg <= 11'h000;
    end else begin
      done_reg <= 1'b0;
      count_reg <= running_reg ? count_reg - 11'h001 : count_reg;
    end
  end
endmodule

// ---- src/apd_cmd_top.sv ----
// task-file command interpreter with avalon register slave
`timescale 1ns/1ps
// How it works
// - a power query in standby or its transitions sets busy, loads 00h into sector count, clears busy, interrupts.
// - a power query while idle sets busy, loads FFh into sector count, clears busy, interrupts.
// - pre-erase moves no data and may end with a write-fault error status.
// - diagnostics run the self tests and leave a result code in the error register.
// - outside IDE mode diagnostics run only when the drive bit selects this card.
// - in IDE mode the drive bit is ignored and the master reports a combined result.
// - result codes: 01h pass, 02h-05h unit faults (only 03h is produced here), 8Xh slave failure in IDE mode.
// - flush writes the pending cache out, only then status shows ready and seek complete.
// - a flush that is not supported ends as an aborted command.
// - no command while busy, and busy rises within 400 ns of the opcode.
// - the interrupt-disable bit, zero after power on, blocks completion interrupts on hostIntrq but not on irq.
module apd_cmd_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic hostIntrq,
  output logic slaveDiagFail,
  input wire logic mediaFaultPin,
  input wire logic cacheDirtyPin,
  input wire logic selfTestFailPin,
  input wire logic peerDiagFailPin
);
  localparam int BsyLimit = apd_pkg::BSY_MAX_CYC;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a[5:2] == ofs[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic [3:0] rawPins;
  assign rawPins = {peerDiagFailPin, selfTestFailPin, cacheDirtyPin, mediaFaultPin};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (srst) begin
          syncA_reg[i] <= 1'b0;
          syncB_reg[i] <= 1'b0;
        end else begin
          syncA_reg[i] <= rawPins[i];
          syncB_reg[i] <= syncA_reg[i];
        end
      end
    end
  endgenerate

  wire mediaFault = syncB_reg[0];
  wire cacheDirty = syncB_reg[1];
  wire selfFail = syncB_reg[2];
  wire peerFail = syncB_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic waitReq_reg;
  logic [31:0] readData_reg;
  logic [7:0] secCnt_reg, secCnt_next;
  logic [7:0] secNum_reg;
  logic [7:0] cylLo_reg;
  logic [7:0] cylHi_reg;
  logic [7:0] drvHead_reg;
  logic [7:0] error_reg, error_next;
  logic [7:0] devCtl_reg;
  logic [7:0] cfg_reg;
  logic [2:0] irqSts_reg, irqSts_next;
  logic [2:0] irqMsk_reg;
  logic busy_reg, busy_next;
  logic errBit_reg, errBit_next;
  logic dwf_reg, dwf_next;
  logic intrqPend_reg, intrqPend_next;
  logic hostIntrq_reg;
  logic irq_reg;
  logic slaveFail_reg;
  logic softPrev_reg;
  logic start_reg;
  apd_pkg::apd_cmd_type kind_reg, kindNext;
  apd_pkg::apd_state_type state_reg, state_next;

  apd_op_if ops();

  apd_op_engine u_engine (
    .core_clk(core_clk),
    .srst(srst),
    .cacheDirty(cacheDirty),
    .mediaFault(mediaFault),
    .ops(ops)
  );

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle on every access
  wire req = avs_read | avs_write;
  wire accept = req & ~waitReq_reg;
  wire wrEn = avs_write & accept & avs_byteenable[0];
  wire rdEn = avs_read & accept;
  wire [7:0] wd = avs_writedata[7:0];
  wire softRst = devCtl_reg[apd_pkg::DC_SRST];
  wire softRelease = softPrev_reg & ~softRst;
  wire nIen = devCtl_reg[apd_pkg::DC_NIEN];
  wire cfgIde = cfg_reg[apd_pkg::CFG_IDE];
  wire cfgSlave = cfg_reg[apd_pkg::CFG_SLAVE];
  wire cfgFlushEn = cfg_reg[apd_pkg::CFG_FLUSH];
  wire [1:0] pwrState = cfg_reg[apd_pkg::CFG_PWR +: 2];
  // task file is frozen while busy
  wire tfWr = wrEn & ~busy_reg;
  wire cmdWr = wrEn & hit(avs_address, apd_pkg::OFS_CMD);
  wire statusRd = rdEn & hit(avs_address, apd_pkg::OFS_CMD);
  wire irqStsRd = rdEn & hit(avs_address, apd_pkg::OFS_IRQSTS);

  // command decode
  wire isQuery = (wd == apd_pkg::OPC_QUERY_A) | (wd == apd_pkg::OPC_QUERY_B);
  wire isErase = wd == apd_pkg::OPC_ERASE;
  wire isDiag = wd == apd_pkg::OPC_DIAG;
  wire isFlush = wd == apd_pkg::OPC_FLUSH;
  wire drvMatch = drvHead_reg[apd_pkg::DH_DRV] == cfgSlave;
  wire diagSkip = isDiag & ~cfgIde & ~drvMatch;
  wire refused = cmdWr & (busy_reg | softRst);
  wire cmdGo = cmdWr & ~busy_reg & ~softRst & ~diagSkip;
  assign kindNext = isQuery ? apd_pkg::CK_QUERY :
                    isErase ? apd_pkg::CK_ERASE :
                    isDiag ? apd_pkg::CK_DIAG :
                    (isFlush & cfgFlushEn) ? apd_pkg::CK_FLUSH :
                    apd_pkg::CK_ABORT;
  wire useEngine = (kindNext == apd_pkg::CK_ERASE) | (kindNext == apd_pkg::CK_DIAG) |
                   (kindNext == apd_pkg::CK_FLUSH);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      apd_pkg::ST_IDLE: begin
        if (cmdGo) begin
          state_next = useEngine ? apd_pkg::ST_RUN : apd_pkg::ST_FIN;
        end
      end
      apd_pkg::ST_RUN: begin
        if (ops.done) begin
          state_next = apd_pkg::ST_IDLE;
        end
      end
      apd_pkg::ST_FIN: state_next = apd_pkg::ST_IDLE;
      default: state_next = apd_pkg::ST_IDLE;
    endcase
    if (softRst) begin
      state_next = apd_pkg::ST_IDLE;
    end
  end

  wire finish = ~softRst & ((state_reg == apd_pkg::ST_FIN) |
                            ((state_reg == apd_pkg::ST_RUN) & ops.done));
  wire finAbort = kind_reg == apd_pkg::CK_ABORT;
  wire finFault = (kind_reg == apd_pkg::CK_ERASE) & ops.fault;
  wire finDiag = finish & (kind_reg == apd_pkg::CK_DIAG);
  wire [7:0] ownCode = selfFail ? apd_pkg::DIAG_BUF : apd_pkg::DIAG_OK;
  // only an IDE master folds the peer's failure into its code
  wire [7:0] diagCode = (cfgIde & ~cfgSlave & peerFail) ?
                        (apd_pkg::DIAG_SLAVE | ownCode) : ownCode;
  wire [7:0] queryCnt = (pwrState == apd_pkg::PWR_IDLE) ?
                        apd_pkg::SECCNT_IDLE : apd_pkg::SECCNT_STANDBY;

  assign busy_next = (softRst | cmdGo) ? 1'b1 :
                     (finish | softRelease) ? 1'b0 : busy_reg;
  assign errBit_next = (softRst | cmdGo) ? 1'b0 : finish ? (finAbort | finFault) : errBit_reg;
  assign dwf_next = (softRst | cmdGo) ? 1'b0 : finish ? finFault : dwf_reg;
  assign error_next = softRelease ? apd_pkg::DIAG_OK :
                      ~finish ? error_reg :
                      finAbort ? apd_pkg::ERR_ABRT :
                      (kind_reg == apd_pkg::CK_DIAG) ? diagCode : 8'h00;
  assign secCnt_next = (finish & (kind_reg == apd_pkg::CK_QUERY)) ? queryCnt :
                       (tfWr & hit(avs_address, apd_pkg::OFS_SECCNT)) ? wd : secCnt_reg;
  // completion wins over a status read in the same cycle
  assign intrqPend_next = finish | (intrqPend_reg & ~statusRd & ~softRst);
  assign irqSts_next = {refused, finish & (finAbort | finFault), finish} |
                       (irqSts_reg & ~{3{irqStsRd}});

  assign ops.start = start_reg;
  assign ops.op = (kind_reg == apd_pkg::CK_ERASE) ? apd_pkg::OP_ERASE :
                  (kind_reg == apd_pkg::CK_DIAG) ? apd_pkg::OP_DIAG : apd_pkg::OP_FLUSH;
  assign ops.secCount = secCnt_reg;
  assign ops.abort = softRst;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  wire [7:0] statusByte = {busy_reg, ~busy_reg, dwf_reg, ~busy_reg, 3'b000, errBit_reg};
  wire [7:0] rdMux = hit(avs_address, apd_pkg::OFS_SECCNT) ? secCnt_reg :
                     hit(avs_address, apd_pkg::OFS_SECNUM) ? secNum_reg :
                     hit(avs_address, apd_pkg::OFS_CYLLO) ? cylLo_reg :
                     hit(avs_address, apd_pkg::OFS_CYLHI) ? cylHi_reg :
                     hit(avs_address, apd_pkg::OFS_DRVHEAD) ? drvHead_reg :
                     hit(avs_address, apd_pkg::OFS_CMD) ? statusByte :
                     hit(avs_address, apd_pkg::OFS_ERROR) ? error_reg :
                     hit(avs_address, apd_pkg::OFS_DEVCTL) ? devCtl_reg :
                     hit(avs_address, apd_pkg::OFS_CFG) ? cfg_reg :
                     hit(avs_address, apd_pkg::OFS_IRQSTS) ? {5'h00, irqSts_reg} :
                     hit(avs_address, apd_pkg::OFS_IRQMSK) ? {5'h00, irqMsk_reg} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      waitReq_reg <= 1'b1;
      readData_reg <= 32'h0000_0000;
    end else begin
      waitReq_reg <= ~(req & waitReq_reg);
      if (avs_read & waitReq_reg) begin
        readData_reg <= {24'h00_0000, rdMux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // task file and control registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      secNum_reg <= apd_pkg::RST_TASK;
      cylLo_reg <= apd_pkg::RST_TASK;
      cylHi_reg <= apd_pkg::RST_TASK;
      drvHead_reg <= apd_pkg::RST_TASK;
      devCtl_reg <= apd_pkg::RST_DEVCTL;
      cfg_reg <= apd_pkg::RST_CFG;
      irqMsk_reg <= apd_pkg::RST_IRQ;
    end else begin
      if (tfWr & hit(avs_address, apd_pkg::OFS_SECNUM)) secNum_reg <= wd;
      if (tfWr & hit(avs_address, apd_pkg::OFS_CYLLO)) cylLo_reg <= wd;
      if (tfWr & hit(avs_address, apd_pkg::OFS_CYLHI)) cylHi_reg <= wd;
      if (tfWr & hit(avs_address, apd_pkg::OFS_DRVHEAD)) drvHead_reg <= wd;
      if (wrEn & hit(avs_address, apd_pkg::OFS_DEVCTL)) devCtl_reg <= {5'h00, wd[2:1], 1'b0};
      if (wrEn & hit(avs_address, apd_pkg::OFS_CFG)) cfg_reg <= {2'b00, wd[5:0]};
      if (wrEn & hit(avs_address, apd_pkg::OFS_IRQMSK)) irqMsk_reg <= wd[2:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= apd_pkg::ST_IDLE;
      kind_reg <= apd_pkg::CK_QUERY;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
      errBit_reg <= 1'b0;
      dwf_reg <= 1'b0;
      error_reg <= apd_pkg::RST_ERROR;
      secCnt_reg <= apd_pkg::RST_TASK;
      softPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (cmdGo) kind_reg <= kindNext;
      start_reg <= cmdGo & useEngine;
      busy_reg <= busy_next;
      errBit_reg <= errBit_next;
      dwf_reg <= dwf_next;
      error_reg <= error_next;
      secCnt_reg <= secCnt_next;
      softPrev_reg <= softRst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      intrqPend_reg <= 1'b0;
      hostIntrq_reg <= 1'b0;
      irqSts_reg <= apd_pkg::RST_IRQ;
      irq_reg <= 1'b0;
      slaveFail_reg <= 1'b0;
    end else begin
      intrqPend_reg <= intrqPend_next;
      hostIntrq_reg <= intrqPend_next & ~nIen;
      irqSts_reg <= irqSts_next;
      irq_reg <= |(irqSts_next & irqMsk_reg);
      if (finDiag & cfgIde & cfgSlave) slaveFail_reg <= selfFail;
    end
  end

  assign avs_waitrequest = waitReq_reg;
  assign avs_readdata = readData_reg;
  assign hostIntrq = hostIntrq_reg;
  assign irq = irq_reg;
  assign slaveDiagFail = slaveFail_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_busy_rise: assert property (cmdGo |-> ##[1:BsyLimit] busy_reg)
    else $error("busy not raised after opcode");
  a_query_standby: assert property (cmdGo && isQuery && pwrState != 2'b00
    |-> ##2 (secCnt_reg == 8'h00 && !busy_reg && intrqPend_reg))
    else $error("standby query result wrong");
  a_query_idle: assert property (cmdGo && isQuery && pwrState == 2'b00
    |-> ##2 (secCnt_reg == 8'hFF && !busy_reg && intrqPend_reg))
    else $error("idle query result wrong");
  a_erase_fault: assert property (finish && finFault |=> dwf_reg && errBit_reg)
    else $error("erase fault not reported");
  a_diag_pass: assert property (finDiag && !selfFail && !peerFail
    |=> error_reg == 8'h01)
    else $error("diag pass code wrong");
  a_diag_skip: assert property (cmdWr && !busy_reg && !softRst && isDiag && !cfgIde
    && !drvMatch |=> !busy_reg)
    else $error("diag ran on unselected card");
  a_diag_ide: assert property (cmdWr && !busy_reg && !softRst && isDiag && cfgIde
    |=> busy_reg)
    else $error("ide diag not started");
  a_diag_slave: assert property (finDiag && cfgIde && !cfgSlave && peerFail
    |=> error_reg == ($past(ownCode) | 8'h80))
    else $error("slave failure code wrong");
  a_flush_ready: assert property (finish && kind_reg == apd_pkg::CK_FLUSH
    |=> statusByte[6] && statusByte[4] && !statusByte[7])
    else $error("flush status wrong");
  a_flush_abort: assert property (cmdGo && isFlush && !cfgFlushEn
    |-> ##2 (error_reg == 8'h04 && errBit_reg))
    else $error("unsupported flush not aborted");
  a_intrq_gate: assert property (hostIntrq_reg |-> !$past(nIen))
    else $error("interrupt escaped disable bit");
  a_done_intrq: assert property (finish |=> !busy_reg && intrqPend_reg)
    else $error("completion not signalled");

  c_query: cover property (cmdGo && isQuery ##2 !busy_reg);
  c_erase: cover property (finish && kind_reg == apd_pkg::CK_ERASE);
  c_diag: cover property (finDiag);
  c_flush: cover property (finish && kind_reg == apd_pkg::CK_FLUSH);
endmodule

// ---- tb/apd_host_model.sv ----
// host side model: avalon master that issues task-file register cycles
`timescale 1ns/1ps
module apd_host_model (
  input wire logic core_clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
  end
  // one access; request held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    // request stands until the rising edge that samples waitrequest low
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule

// ---- tb/ata_power_erase_diag_flush_cmds_tb.sv ----
// self-checking bench of the command interpreter
`timescale 1ns/1ps
module ata_power_erase_diag_flush_cmds_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0] avsByteenable;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic irq;
  logic hostIntrq;
  logic slaveDiagFail;
  logic mediaFaultPin = 1'b0;
  logic cacheDirtyPin = 1'b0;
  logic selfTestFailPin = 1'b0;
  logic peerDiagFailPin = 1'b0;
  logic [7:0] q;
  int n_fail = 0;
  int compares = 0;

  apd_cmd_top dut_u (.core_clk(core_clk), .srst(srst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .irq(irq), .hostIntrq(hostIntrq),
    .slaveDiagFail(slaveDiagFail),
    .mediaFaultPin(mediaFaultPin), .cacheDirtyPin(cacheDirtyPin),
    .selfTestFailPin(selfTestFailPin), .peerDiagFailPin(peerDiagFailPin));
  apd_host_model host_u (.core_clk(core_clk), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a);
    host_u.xfer(1'b0, a, 8'h00, q);
  endtask

  // completion: irq raised, interrupt pin as expected, both cleared by reads
  task automatic finish(input logic intr);
    @(negedge core_clk);
    while (irq !== 1'b1) begin
      @(negedge core_clk);
    end
    chk("hostIntrq", {7'h00, hostIntrq}, {7'h00, intr});
    rd(apd_pkg::OFS_IRQSTS);
    chk("irqDone", {7'h00, q[apd_pkg::IRQ_DONE]}, 8'h01);
    @(negedge core_clk);
    chk("irqCleared", {7'h00, irq}, 8'h00);
    rd(apd_pkg::OFS_CMD);
    // pin updates on the acknowledging edge, look once it has settled
    @(negedge core_clk);
    chk("intrqCleared", {7'h00, hostIntrq}, 8'h00);
  endtask

  task automatic t_reset();
    rd(apd_pkg::OFS_ERROR);
    chk("errorRst", q, apd_pkg::RST_ERROR);
    rd(apd_pkg::OFS_DEVCTL);
    chk("devctlRst", q, apd_pkg::RST_DEVCTL);
    rd(apd_pkg::OFS_CFG);
    chk("cfgRst", q, apd_pkg::RST_CFG);
    rd(6'h3C);
    chk("unmapped", q, 8'h00);
    wr(apd_pkg::OFS_IRQMSK, 8'h07);
  endtask

  task automatic t_query();
    wr(apd_pkg::OFS_SECCNT, 8'h55);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_QUERY_A);
    finish(1'b1);
    rd(apd_pkg::OFS_SECCNT);
    chk("seccntIdle", q, 8'hFF);
    for (int p = 1; p < 4; p++) begin
      wr(apd_pkg::OFS_CFG, {2'b00, p[1:0], 4'h4});
      wr(apd_pkg::OFS_CMD, p[0] ? apd_pkg::OPC_QUERY_B : apd_pkg::OPC_QUERY_A);
      finish(1'b1);
      rd(apd_pkg::OFS_SECCNT);
      chk("seccntStandby", q, 8'h00);
    end
    wr(apd_pkg::OFS_CFG, 8'h04);
    wr(apd_pkg::OFS_DEVCTL, 8'h02);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_QUERY_A);
    finish(1'b0);
    wr(apd_pkg::OFS_DEVCTL, 8'h00);
  endtask

  task automatic t_erase();
    // parameters first, opcode last; count 0 means 256 sectors
    wr(apd_pkg::OFS_SECNUM, 8'h12);
    wr(apd_pkg::OFS_CYLLO, 8'h34);
    wr(apd_pkg::OFS_CYLHI, 8'h56);
    wr(apd_pkg::OFS_DRVHEAD, 8'hE7);
    wr(apd_pkg::OFS_SECCNT, 8'h00);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_ERASE);
    rd(apd_pkg::OFS_CMD);
    chk("busySet", {7'h00, q[7]}, 8'h01);
    // deliberate command while busy must be refused
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_FLUSH);
    rd(apd_pkg::OFS_IRQSTS);
    chk("refused", q, 8'h04);
    finish(1'b1);
    chk("eraseOk", q & 8'hA1, 8'h00);
    mediaFaultPin <= 1'b1;
    wr(apd_pkg::OFS_SECCNT, 8'h01);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_ERASE);
    finish(1'b1);
    chk("eraseFault", q & 8'hA1, 8'h21);
    mediaFaultPin <= 1'b0;
  endtask

  task automatic t_diag();
    wr(apd_pkg::OFS_DRVHEAD, 8'h00);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_DIAG);
    finish(1'b1);
    rd(apd_pkg::OFS_ERROR);
    chk("diagOk", q, apd_pkg::DIAG_OK);
    selfTestFailPin <= 1'b1;
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_DIAG);
    finish(1'b1);
    rd(apd_pkg::OFS_ERROR);
    chk("diagBuf", q, apd_pkg::DIAG_BUF);
    selfTestFailPin <= 1'b0;
    // card mode, other drive selected: nothing happens
    wr(apd_pkg::OFS_DRVHEAD, 8'h10);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_DIAG);
    rd(apd_pkg::OFS_CMD);
    chk("diagSkipBusy", {7'h00, q[7]}, 8'h00);
    rd(apd_pkg::OFS_ERROR);
    chk("diagSkipErr", q, apd_pkg::DIAG_BUF);
    // ide master ignores the drive bit and folds in the peer result
    peerDiagFailPin <= 1'b1;
    wr(apd_pkg::OFS_CFG, 8'h05);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_DIAG);
    finish(1'b1);
    rd(apd_pkg::OFS_ERROR);
    chk("diagSlave", q, 8'h81);
    peerDiagFailPin <= 1'b0;
    // ide slave keeps its own code and flags its failure on the pin
    selfTestFailPin <= 1'b1;
    wr(apd_pkg::OFS_CFG, 8'h07);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_DIAG);
    finish(1'b1);
    chk("slaveFailPin", {7'h00, slaveDiagFail}, 8'h01);
    rd(apd_pkg::OFS_ERROR);
    chk("slaveOwnCode", q, apd_pkg::DIAG_BUF);
    selfTestFailPin <= 1'b0;
  endtask

  task automatic t_softrst();
    wr(apd_pkg::OFS_DEVCTL, 8'h04);
    rd(apd_pkg::OFS_CMD);
    chk("softBusy", {7'h00, q[7]}, 8'h01);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_QUERY_A);
    rd(apd_pkg::OFS_IRQSTS);
    chk("softRefused", q, 8'h04);
    wr(apd_pkg::OFS_DEVCTL, 8'h00);
    rd(apd_pkg::OFS_ERROR);
    chk("softErr", q, apd_pkg::DIAG_OK);
    rd(apd_pkg::OFS_CMD);
    chk("softStatus", q, 8'h50);
  endtask

  task automatic t_flush();
    cacheDirtyPin <= 1'b1;
    wr(apd_pkg::OFS_CFG, 8'h04);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_FLUSH);
    finish(1'b1);
    chk("flushStatus", q, 8'h50);
    wr(apd_pkg::OFS_CFG, 8'h00);
    wr(apd_pkg::OFS_CMD, apd_pkg::OPC_FLUSH);
    finish(1'b1);
    chk("abortStatus", q & 8'h81, 8'h01);
    rd(apd_pkg::OFS_ERROR);
    chk("abortError", q, apd_pkg::ERR_ABRT);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_query();
    t_erase();
    t_diag();
    t_flush();
    t_softrst();
    final_report();
  end

  // whole run needs well under two thousand cycles, 1024 of them for the 256-sector erase
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
